// file: verilog/blpp_pkg.sv
// shared constants and types for the buffer load and page program sequencer
`default_nettype none

package blpp_pkg;

  // ----------------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WR_BUF1  = 8'h84;  // load first sram buffer
  localparam logic [7:0] OP_WR_BUF2  = 8'h87;  // load second sram buffer
  localparam logic [7:0] OP_PRG_BUF1 = 8'h88;  // first buffer to page, no erase
  localparam logic [7:0] OP_PRG_BUF2 = 8'h89;  // second buffer to page, no erase
  localparam logic [7:0] OP_STATUS   = 8'hD7;  // continuous status read

  // ----------------------------------------------------------------------
  // memory geometry and address layout
  // ----------------------------------------------------------------------
  localparam int         PAGE_BYTES  = 264;
  localparam int         PAGE_COUNT  = 32768;
  localparam int         COL_W       = 9;
  localparam int         PAGE_W      = 15;
  localparam int         ADDR_W      = 24;
  localparam int         COL_LSB     = 0;      // byte within page
  localparam int         PAGE_LSB    = 9;      // page number field
  localparam logic [8:0] COL_LAST    = 9'h107; // last byte of a page
  localparam logic [1:0] ADDR_LAST   = 2'h2;   // third address byte index

  // ----------------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------------
  localparam int         STAT_RDY_HI = 15;
  localparam int         STAT_RDY_LO = 7;
  localparam logic [15:0] STAT_RST   = 16'h0000;

  // ----------------------------------------------------------------------
  // serial clock rates and the write fifo
  // ----------------------------------------------------------------------
  localparam int         MCLK_MHZ    = 125;
  localparam int         SCLK_MAX_MHZ = 85;
  localparam int         FIFO_DEPTH  = 32;

  // one byte bound for the flash array
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0]  col;
    logic [7:0]        data;
  } blpp_word_t;

  localparam int         WORD_W      = $bits(blpp_word_t);

  typedef enum logic [2:0] {
    SP_OPC   = 3'b000,
    SP_ADDR  = 3'b001,
    SP_DATA  = 3'b010,
    SP_STAT  = 3'b011,
    SP_ARMED = 3'b100,
    SP_SKIP  = 3'b101
  } blpp_spi_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_RUN   = 2'b01,
    PG_DRAIN = 2'b10
  } blpp_prg_t;

endpackage

`default_nettype wire

// file: verilog/blpp_fifo.sv
// synchronous fifo with valid and ready on both sides
`default_nettype none

module blpp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  // drain side
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic [WIDTH-1:0]      rdData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_ff;
  logic [PW-1:0]    rdPtr_ff;
  logic [PW:0]      count_ff;
  wire              doWr = wrValid & wrReady;
  wire              doRd = rdValid & rdReady;

  // status from the occupancy count
  assign wrReady = (count_ff != (PW+1)'(DEPTH));
  assign rdValid = (count_ff != '0);
  assign rdData  = mem[rdPtr_ff];

  // storage has no reset, it is qualified by the count
  always_ff @(posedge mclk)
  begin
    if (doWr)
      mem[wrPtr_ff] <= wrData;
  end

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (doWr)
        wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doRd)
        rdPtr_ff <= rdPtr_ff + 1'b1;
      if (doWr && !doRd)
        count_ff <= count_ff + 1'b1;
      else if (doRd && !doWr)
        count_ff <= count_ff - 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: verilog/blpp_sequencer.sv
// serial flash command sequencer: buffer load, page program, status read
//
// Contract
// - opcode 87h plus 24-bit address starts writes into the second buffer
// - up to 264 following bytes land in successive buffer locations
// - address bytes arrive most significant first and are assembled so
// - opcode 89h plus address programs second buffer into a page, no erase
// - program updates every byte of the page from all 264 buffer bytes
// - address is a byte address; low bits zero select a page's first byte
// - main memory is 32768 pages of 264 bytes, programmed whole
// - program finishes on its own without further host bus activity
// - two independent buffers, each loaded and programmed separately
// - serial interface accepts command, address and data up to 85 MHz; pins are sampled at 125 MHz mclk, so sclk must stay well below 62.5 MHz
// - opcode D7h streams two status bytes repeatedly with fresh values
// - ready flag sits at bits 15 and 7, low while busy
// - chip select release ends status read and floats the data output
`default_nettype none

module blpp_sequencer (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // serial pins from the host
  input  wire logic                 sclk,
  input  wire logic                 csN,
  input  wire logic                 mosi,
  // serial data output, three-state
  output logic                      misoOut,
  output logic                      misoOe,
  // write port toward the flash array
  output blpp_pkg::blpp_word_t      arrWord,
  output logic                      arrValid,
  input  wire logic                 arrReady,
  // ready level for the system
  output logic                      ready
);

  import blpp_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [1:0] sclkS_ff;
  logic [1:0] csS_ff;
  logic [1:0] mosiS_ff;
  logic       sclkPrev_ff;
  logic       csPrev_ff;

  // two flops per pin; edges compare stage two with its delayed copy
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkS_ff    <= 2'h0;
      csS_ff      <= 2'h3;
      mosiS_ff    <= 2'h0;
      sclkPrev_ff <= 1'b0;
      csPrev_ff   <= 1'b1;
    end
    else
    begin
      sclkS_ff    <= {sclkS_ff[0], sclk};
      csS_ff      <= {csS_ff[0], csN};
      mosiS_ff    <= {mosiS_ff[0], mosi};
      sclkPrev_ff <= sclkS_ff[1];
      csPrev_ff   <= csS_ff[1];
    end
  end

  // oversampled at mclk, so usable sclk is well below mclk / 2
  wire sclkRise = sclkS_ff[1] & ~sclkPrev_ff;
  wire sclkFall = ~sclkS_ff[1] & sclkPrev_ff;
  wire csActive = ~csS_ff[1];
  wire csRise   = csS_ff[1] & ~csPrev_ff;
  wire mosiBit  = mosiS_ff[1];

  // ----------------------------------------------------------------------
  // byte assembly, mode 0 and mode 3 sample on rising sclk
  // ----------------------------------------------------------------------
  logic [2:0] bitCnt_ff;
  logic [6:0] shReg_ff;

  wire        byteDone = csActive & sclkRise & (bitCnt_ff == 3'h7);
  wire [7:0]  rxByte   = {shReg_ff, mosiBit};

  // bit counter restarts whenever chip select is released
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitCnt_ff <= 3'h0;
      shReg_ff  <= 7'h00;
    end
    else if (!csActive)
      bitCnt_ff <= 3'h0;
    else if (sclkRise)
    begin
      bitCnt_ff <= bitCnt_ff + 3'h1;
      shReg_ff  <= rxByte[6:0];
    end
  end

  // ----------------------------------------------------------------------
  // command decode and serial state
  // ----------------------------------------------------------------------
  blpp_spi_t         spiSt_ff;
  blpp_prg_t         prgSt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [1:0]        addrCnt_ff;
  logic              isPrg_ff;
  logic              selBuf_ff;
  logic [COL_W-1:0]  col_ff;

  wire busy      = (prgSt_ff != PG_IDLE);
  wire isWr1     = (rxByte == OP_WR_BUF1);
  wire isWr2     = (rxByte == OP_WR_BUF2);
  wire isPrg1    = (rxByte == OP_PRG_BUF1);
  wire isPrg2    = (rxByte == OP_PRG_BUF2);
  wire isStat    = (rxByte == OP_STATUS);
  wire opAccept  = (isWr1 | isWr2 | isPrg1 | isPrg2) & ~busy;
  wire [ADDR_W-1:0] addrNext = {addr_ff[ADDR_W-9:0], rxByte};
  wire addrDone  = byteDone & (spiSt_ff == SP_ADDR) & (addrCnt_ff == ADDR_LAST);
  wire [COL_W-1:0] colStart = addrNext[COL_LSB +: COL_W];
  // a start column past the page end wraps to the first byte
  wire [COL_W-1:0] colFirst = (colStart > COL_LAST) ? '0 : colStart;
  wire [COL_W-1:0] colStep  = (col_ff == COL_LAST) ? '0 : col_ff + 1'b1;
  wire bufWrEn   = byteDone & (spiSt_ff == SP_DATA);
  wire prgStart  = csRise & (spiSt_ff == SP_ARMED);

  // next serial state on each received byte
  blpp_spi_t nxt_spiSt;
  always_comb
  begin
    nxt_spiSt = spiSt_ff;
    if (!csActive)
      nxt_spiSt = SP_OPC;
    else if (byteDone)
    begin
      case (spiSt_ff)
        SP_OPC:
          if (isStat)
            nxt_spiSt = SP_STAT;
          else if (opAccept)
            nxt_spiSt = SP_ADDR;
          else
            nxt_spiSt = SP_SKIP;
        SP_ADDR:
          if (addrCnt_ff == ADDR_LAST)
            nxt_spiSt = isPrg_ff ? SP_ARMED : SP_DATA;
        SP_DATA:  nxt_spiSt = SP_DATA;
        SP_STAT:  nxt_spiSt = SP_STAT;
        SP_ARMED: nxt_spiSt = SP_ARMED;
        SP_SKIP:  nxt_spiSt = SP_SKIP;
        default:  nxt_spiSt = SP_SKIP;
      endcase
    end
  end

  // serial state; a release before the third address byte leaves no trace
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      spiSt_ff <= SP_OPC;
    else
      spiSt_ff <= nxt_spiSt;
  end

  // opcode attributes and address capture
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      isPrg_ff   <= 1'b0;
      selBuf_ff  <= 1'b0;
      addr_ff    <= '0;
      addrCnt_ff <= 2'h0;
    end
    else if (byteDone && spiSt_ff == SP_OPC)
    begin
      isPrg_ff   <= isPrg1 | isPrg2;
      selBuf_ff  <= isWr2 | isPrg2;
      addrCnt_ff <= 2'h0;
    end
    else if (byteDone && spiSt_ff == SP_ADDR)
    begin
      addr_ff    <= addrNext;
      addrCnt_ff <= addrCnt_ff + 2'h1;
    end
  end

  // column pointer for buffer loads
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      col_ff <= '0;
    else if (addrDone)
      col_ff <= colFirst;
    else if (bufWrEn)
      col_ff <= colStep;
  end

  // ----------------------------------------------------------------------
  // the two sram page buffers
  // ----------------------------------------------------------------------
  logic [7:0]       bufOne [PAGE_BYTES];
  logic [7:0]       bufTwo [PAGE_BYTES];
  logic [COL_W-1:0] prgIdx_ff;
  logic             prgBuf_ff;

  // buffers are separate arrays, a load into one never touches the other
  always_ff @(posedge mclk)
  begin
    if (bufWrEn && !selBuf_ff)
      bufOne[col_ff] <= rxByte;
    if (bufWrEn && selBuf_ff)
      bufTwo[col_ff] <= rxByte;
  end

  wire [7:0] bufRd = prgBuf_ff ? bufTwo[prgIdx_ff] : bufOne[prgIdx_ff];

  // ----------------------------------------------------------------------
  // page program engine, feeds the array through the fifo
  // ----------------------------------------------------------------------
  logic [PAGE_W-1:0] prgPage_ff;
  logic              fifoWrRdy;
  logic              fifoRdVld;
  blpp_word_t        fifoRdData;
  logic              arrVld_ff;
  blpp_word_t        arrWord_ff;

  wire        fifoWrVld = (prgSt_ff == PG_RUN);
  wire        push      = fifoWrVld & fifoWrRdy;
  wire        prgLast   = push & (prgIdx_ff == COL_LAST);
  wire        fifoRdRdy = ~arrVld_ff | arrReady;
  blpp_word_t pushWord;

  // one word per byte; no erase step exists on this path
  assign pushWord = '{page: prgPage_ff, col: prgIdx_ff, data: bufRd};

  // engine walks all 264 columns; a full fifo simply stalls it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prgSt_ff   <= PG_IDLE;
      prgIdx_ff  <= '0;
      prgPage_ff <= '0;
      prgBuf_ff  <= 1'b0;
    end
    else
    begin
      case (prgSt_ff)
        PG_IDLE:
          if (prgStart)
          begin
            prgSt_ff   <= PG_RUN;
            prgIdx_ff  <= '0;
            prgPage_ff <= addr_ff[PAGE_LSB +: PAGE_W];
            prgBuf_ff  <= selBuf_ff;
          end
        PG_RUN:
          if (prgLast)
            prgSt_ff <= PG_DRAIN;
          else if (push)
            prgIdx_ff <= prgIdx_ff + 1'b1;
        PG_DRAIN:
          if (!fifoRdVld && !arrVld_ff)
            prgSt_ff <= PG_IDLE;
        default:
          prgSt_ff <= PG_IDLE;
      endcase
    end
  end

  blpp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wrValid (fifoWrVld),
    .wrReady (fifoWrRdy),
    .wrData  (pushWord),
    .rdValid (fifoRdVld),
    .rdReady (fifoRdRdy),
    .rdData  (fifoRdData)
  );

  // output register toward the array, holds until accepted
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arrVld_ff  <= 1'b0;
      arrWord_ff <= '0;
    end
    else if (fifoRdVld && fifoRdRdy)
    begin
      arrVld_ff  <= 1'b1;
      arrWord_ff <= fifoRdData;
    end
    else if (arrReady)
      arrVld_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // status stream, shifted out on falling sclk
  // ----------------------------------------------------------------------
  logic [3:0]  statIdx_ff;
  logic [15:0] statLat_ff;
  logic        misoOut_ff;
  logic        misoOe_ff;
  logic        ready_ff;
  logic [15:0] liveStat;

  // ready high at both bit positions, other bits read as zero
  always_comb
  begin
    liveStat              = STAT_RST;
    liveStat[STAT_RDY_HI] = ~busy;
    liveStat[STAT_RDY_LO] = ~busy;
  end

  // a new snapshot starts each pair so the host sees fresh values
  wire [15:0] statSrc = (statIdx_ff == 4'h0) ? liveStat : statLat_ff;
  wire        statBit = statSrc[4'hF - statIdx_ff];
  wire        statShift = csActive & sclkFall & (spiSt_ff == SP_STAT);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      statIdx_ff <= 4'h0;
      statLat_ff <= STAT_RST;
      misoOut_ff <= 1'b0;
      misoOe_ff  <= 1'b0;
    end
    else if (!csActive)
    begin
      statIdx_ff <= 4'h0;
      misoOe_ff  <= 1'b0;
    end
    else if (statShift)
    begin
      if (statIdx_ff == 4'h0)
        statLat_ff <= liveStat;
      statIdx_ff <= statIdx_ff + 4'h1;
      misoOut_ff <= statBit;
      misoOe_ff  <= 1'b1;
    end
  end

  // ready level mirrors the engine, registered for a clean output
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ready_ff <= 1'b1;
    else
      ready_ff <= ~busy;
  end

  assign misoOut  = misoOut_ff;
  assign misoOe   = misoOe_ff;
  assign arrWord  = arrWord_ff;
  assign arrValid = arrVld_ff;
  assign ready    = ready_ff;

endmodule

`default_nettype wire

// file: verif/blpp_seq_properties.sv
// concurrent checks on the sequencer's ports
`default_nettype none

module blpp_seq_chk (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // serial pins
  input wire logic                 csN,
  input wire logic                 misoOe,
  // array port and ready level
  input wire blpp_pkg::blpp_word_t arrWord,
  input wire logic                 arrValid,
  input wire logic                 arrReady,
  input wire logic                 ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import blpp_pkg::*;

  // ------------------------------------------------------------------
  // helper: last accepted word, so steps can span gaps of back-pressure
  // ------------------------------------------------------------------
  wire logic       accept;
  wire logic       midPage;
  logic [8:0]      prevCol_ff;
  logic [14:0]     prevPage_ff;
  assign accept  = arrValid && arrReady;
  assign midPage = accept && (arrWord.col != 9'h000);

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      prevCol_ff  <= 9'h000;
      prevPage_ff <= 15'h0000;
    end
    else if (accept)
    begin
      prevCol_ff  <= arrWord.col;
      prevPage_ff <= arrWord.page;
    end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_lastWord;
    accept && (arrWord.col == COL_LAST);
  endsequence
  sequence s_feed;
    ##[1:8] arrValid;
  endsequence

  property p_oeIdle;   csN [*5] |-> !misoOe;                          endproperty
  property p_oeStart;  $rose(misoOe) |-> !csN;                        endproperty
  property p_holdWord; arrValid && !arrReady |=> arrValid && $stable(arrWord); endproperty
  property p_colStep;  midPage |-> arrWord.col == prevCol_ff + 9'h001; endproperty
  property p_pageSame; midPage |-> arrWord.page == prevPage_ff;       endproperty
  property p_busy;     arrValid |-> !ready;                           endproperty
  property p_csStart;  $fell(ready) |-> csN;                          endproperty
  property p_feed;     $fell(ready) |-> s_feed;                       endproperty
  property p_done;     s_lastWord |-> ##[1:4] ready;                  endproperty

  a_oeIdle:   assert property (p_oeIdle)   else $error("miso enabled while deselected");
  a_oeStart:  assert property (p_oeStart)  else $error("miso enabled outside a frame");
  a_holdWord: assert property (p_holdWord) else $error("array word changed unaccepted");
  a_colStep:  assert property (p_colStep)  else $error("column not successive");
  a_pageSame: assert property (p_pageSame) else $error("page changed inside program");
  a_busy:     assert property (p_busy)     else $error("ready high during program");
  a_csStart:  assert property (p_csStart)  else $error("program began with select low");
  a_feed:     assert property (p_feed)     else $error("program produced no words");
  a_done:     assert property (p_done)     else $error("ready late after last word");
endmodule

bind blpp_sequencer blpp_seq_chk chk (.mclk(mclk), .rst_n(rst_n), .csN(csN), .misoOe(misoOe),
  .arrWord(arrWord), .arrValid(arrValid), .arrReady(arrReady), .ready(ready));

`default_nettype wire

// file: verif/blpp_host_model.sv
// host side model: spi master (mode 0) driving the sequencer's serial pins
`default_nettype none

module blpp_host_model (
  // clock for pacing
  input  wire logic mclk,
  // serial pins
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  input  wire logic misoOut,
  input  wire logic misoOe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
  end

  // one byte each way, msb first; 9 mclk a bit, well inside the synchroniser
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge mclk) mosi = tx[i];
      repeat (4) @(negedge mclk);
      rx[i] = misoOe ? misoOut : 1'bx;
      sclk = 1'b1;
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
    end
  endtask

  // opcode then address bytes, high byte first
  task automatic cmd(input logic [7:0] opc, input logic [23:0] addr, input int nAddr);
    logic [7:0] rx;
    @(negedge mclk) csN = 1'b0;
    xfer(opc, rx);
    for (int b = 0; b < nAddr; b++)
      xfer(addr[23 - 8 * b -: 8], rx);
  endtask

  // release: sclk stays low, mosi shows no stale level
  task automatic endFrame();
    @(negedge mclk) csN = 1'b1;
    mosi = ~mosi;
    repeat (6) @(negedge mclk);
  endtask
endmodule

`default_nettype wire

// file: verif/testbench.sv
// self-checking testbench for the buffer load and page program sequencer
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import blpp_pkg::*;

  logic       mclk;
  logic       rst_n;
  logic       sclk;
  logic       csN;
  logic       mosi;
  logic       misoOut;
  logic       misoOe;
  logic       arrValid;
  logic       arrReady;
  logic       ready;
  logic       stallEn;
  blpp_word_t arrWord;
  blpp_word_t got[$];
  int         cyc = 0;
  int         fail_count = 0;
  int         total_checks = 0;

  blpp_sequencer uut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut), .misoOe(misoOe), .arrWord(arrWord), .arrValid(arrValid),
    .arrReady(arrReady), .ready(ready));
  blpp_host_model host (.mclk(mclk), .sclk(sclk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut), .misoOe(misoOe));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // array side: long stalls fill the fifo so the engine has to wait
  always @(negedge mclk)
  begin
    cyc++;
    arrReady <= !(stallEn && (cyc % 64) < 40);
  end
  always @(posedge mclk)
    if (rst_n === 1'b1 && arrValid === 1'b1 && arrReady === 1'b1)
      got.push_back(arrWord);

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chkVal(input logic [31:0] exp, input logic [31:0] act);
    total_checks++;
    if (act !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  task automatic chkBit(input logic exp, input logic act);
    chkVal({31'h0, exp}, {31'h0, act});
  endtask

  function automatic logic [7:0] pat(input logic [7:0] seed, input int k);
    return 8'(k * 7) ^ seed;
  endfunction

  task automatic loadBuf(input logic [7:0] opc, input logic [8:0] col, input logic [7:0] seed);
    logic [7:0] rx;
    host.cmd(opc, {15'h0000, col}, 3);
    for (int k = 0; k < PAGE_BYTES; k++)
      host.xfer(pat(seed, k), rx);
    host.endFrame();
  endtask

  // program, poll status until done, then judge every array word
  task automatic progCheck(input logic [7:0] opc, input logic [23:0] addr,
                           input logic [8:0] col0, input logic [7:0] seed);
    logic [7:0] hi;
    logic [7:0] lo;
    blpp_word_t exp;
    int         n;
    got.delete();
    host.cmd(opc, addr, 3);
    host.endFrame();
    host.cmd(OP_STATUS, 24'h000000, 0);
    host.xfer(8'h00, hi);
    host.xfer(8'h00, lo);
    chkVal(32'h0, {16'h0, hi, lo});
    for (n = 0; n < 40 && hi[7] !== 1'b1; n++)
    begin
      host.xfer(8'h00, hi);
      host.xfer(8'h00, lo);
      chkVal({16'h0, hi[7], 7'h00, hi[7], 7'h00}, {16'h0, hi, lo});
    end
    if (n == 40)
    begin
      fail_count++;
      test_done();
    end
    host.endFrame();
    chkBit(1'b0, misoOe);
    chkBit(1'b1, ready);
    chkVal(32'(PAGE_BYTES), 32'(got.size()));
    for (int c = 0; c < PAGE_BYTES && c < got.size(); c++)
    begin
      exp.page = addr[23:9];
      exp.col  = 9'(c);
      exp.data = pat(seed, (c + PAGE_BYTES - int'(col0)) % PAGE_BYTES);
      chkVal(exp, got[c]);
    end
  endtask

  task automatic t_load_program();
    stallEn = 1'b1;
    loadBuf(OP_WR_BUF2, 9'h000, 8'hA5);
    progCheck(OP_PRG_BUF2, 24'h1FFE00, 9'h000, 8'hA5);
    stallEn = 1'b0;
  endtask

  // first buffer loaded from column 5 with wrap; second must survive it
  task automatic t_two_buffers();
    loadBuf(OP_WR_BUF1, 9'h005, 8'h3C);
    progCheck(OP_PRG_BUF1, 24'h000600, 9'h005, 8'h3C);
    progCheck(OP_PRG_BUF2, 24'h000200, 9'h000, 8'hA5);
  endtask

  // program cut short after two address bytes must do nothing
  task automatic t_short_program();
    got.delete();
    host.cmd(OP_PRG_BUF2, 24'h000400, 2);
    host.endFrame();
    repeat (20) @(negedge mclk);
    chkBit(1'b1, ready);
    chkVal(32'h0, 32'(got.size()));
  endtask

  // a load sent while a program runs is refused; buffer one must stay intact
  task automatic t_busy_refuse();
    logic [7:0] rx;
    int         n;
    got.delete();
    host.cmd(OP_PRG_BUF1, 24'h000800, 3);
    host.endFrame();
    chkBit(1'b0, ready);
    host.cmd(OP_WR_BUF1, 24'h000000, 3);
    for (int k = 0; k < 4; k++)
      host.xfer(8'hFF, rx);
    host.endFrame();
    for (n = 0; n < 2000 && ready !== 1'b1; n++)
      @(negedge mclk);
    if (n == 2000)
    begin
      fail_count++;
      test_done();
    end
    chkVal(32'(PAGE_BYTES), 32'(got.size()));
    progCheck(OP_PRG_BUF1, 24'h000A00, 9'h005, 8'h3C);
  endtask

  initial
  begin
    rst_n = 1'b0;
    stallEn = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    chkBit(1'b1, ready);
    t_load_program();
    t_two_buffers();
    t_short_program();
    t_busy_refuse();
    test_done();
  end
endmodule

`default_nettype wire
